// ### common/srdm_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Function
// - segment 255 replaced by redirect segment value
// - refresh request every refresh_interval clock cycles
// - refresh has priority over normal accesses, not over direct commands
// - automatic refresh only while refresh_ctrl_on set
// - request flag set requests one direct command
// - acknowledge flag set after command executed
// - acknowledge held until request flag cleared
// - acknowledge cleared one clock after request clears
// - direct pin pattern drives SDRAM control pins
// - mode register set drives fixed mode word address, bit 10 from pattern bit 0
// - size select picks two or four banks
// - bank windows start at fixed SDRAM addresses
// - second ROM base follows ROM size field
// - second chip select enable gates ROM select
// - direct mode bypasses normal access machines
//////////////////////////////////////////////////////////////////////////////
package srdm_pkg;
  localparam logic [3:0]  OFF_SEG_REDIRECT = 4'h0;
  localparam logic [3:0]  OFF_REFRESH      = 4'h4;
  localparam logic [3:0]  OFF_CONTROL      = 4'h8;
  localparam logic [3:0]  OFF_PINS         = 4'hC;
  localparam logic [15:0] RST_SEG_REDIRECT = 16'h00FF;
  localparam logic [15:0] RST_REFRESH      = 16'h03E8;
  localparam logic [15:0] RST_CONTROL      = 16'h0000;
  localparam logic [15:0] RST_PINS         = 16'h0000;
  localparam int          BIT_REQ          = 0;
  localparam int          BIT_ACK          = 1;
  localparam int          BIT_SIZE         = 2;
  localparam int          BIT_REFON        = 3;
  localparam logic [7:0]  SEG_REDIRECTED   = 8'hFF;
  // mode word: burst length 4, linear wrap, cas latency 3
  localparam logic [11:0] MODE_WORD        = 12'h032;
  localparam logic [23:0] BANK_BASE        = 24'h800000;
  localparam logic [23:0] ROM2_NONE        = 24'h000000;
  localparam logic [23:0] ROM2_B110        = 24'h200000;
  localparam logic [23:0] ROM2_B101        = 24'h100000;
  localparam logic [23:0] ROM2_B100        = 24'h080000;
  localparam logic [23:0] ROM2_B011        = 24'h040000;
  localparam logic [23:0] ROM2_OTHER       = 24'h020000;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  typedef enum logic [1:0] {DM_IDLE, DM_EXEC, DM_ACK} srdm_dstate_t;
endpackage

// ### logic/srdm_ctrl.sv
`timescale 1ns/100ps
module srdm_ctrl (
  input  wire logic        clock,            // 50 MHz clock
  input  wire logic        rst,              // sync reset, active high
  input  wire logic [3:0]  awaddr,           // write address
  input  wire logic        awvalid,          // write address valid
  output logic             awready,          // write address ready
  input  wire logic [31:0] wdata,            // write data
  input  wire logic [3:0]  wstrb,            // write byte strobes
  input  wire logic        wvalid,           // write data valid
  output logic             wready,           // write data ready
  output logic [1:0]       bresp,            // write response
  output logic             bvalid,           // write response valid
  input  wire logic        bready,           // write response ready
  input  wire logic [3:0]  araddr,           // read address
  input  wire logic        arvalid,          // read address valid
  output logic             arready,          // read address ready
  output logic [31:0]      rdata,            // read data
  output logic [1:0]       rresp,            // read response
  output logic             rvalid,           // read data valid
  input  wire logic        rready,           // read data ready
  input  wire logic [23:0] accAddr,          // cpu byte address
  input  wire logic        accValid,         // access request
  input  wire logic [2:0]  romSizeField,     // rom size reset field
  input  wire logic        secondChipSelEn,  // second chip select enable strap
  input  wire logic        fsmCsN,           // normal machine chip select
  input  wire logic        fsmRasN,          // normal machine ras
  input  wire logic        fsmCasN,          // normal machine cas
  input  wire logic        fsmWeN,           // normal machine write enable
  input  wire logic        fsmCke,           // normal machine clock enable
  input  wire logic [11:0] fsmAddr,          // normal machine address
  output logic [23:0]      mappedAddr,       // address after redirect
  output logic [1:0]       bankSel,          // sdram bank of access
  output logic             sdramHit,         // access targets sdram
  output logic             accGrant,         // normal access granted
  output logic             refreshReq,       // refresh request pulse
  output logic [23:0]      rom2Base,         // second rom base
  output logic             rom2Allowed,      // second rom possible
  output logic             secondRomSelN,    // second rom select, low active
  output logic             sdramCsN,         // sdram chip select
  output logic             sdramRasN,        // sdram ras
  output logic             sdramCasN,        // sdram cas
  output logic             sdramWeN,         // sdram write enable
  output logic             sdramCke,         // sdram clock enable
  output logic [11:0]      sdramAddr         // sdram address lines
);

  logic [15:0] segRedirect;
  logic [15:0] refreshInterval;
  logic        reqFlag;
  logic        ackFlag;
  logic        sizeSel;
  logic        refreshOn;
  logic [15:0] pinPattern;
  logic [15:0] refCount;
  logic        refPending;
  logic        awHeld;
  logic        wHeld;
  logic [3:0]  awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0]  wStrbQ;
  logic        doWrite;
  logic [23:0] next_mapped;
  logic [1:0]  next_bank;
  logic        next_hit;
  logic [23:0] next_rom2;
  logic        strapTaken;
  logic        cselStrap;
  srdm_pkg::srdm_dstate_t dState;

  //////////////////////////////////////////////////////////////////////////////
  // axi write: address and data taken in either order, answer after both
  assign doWrite = awHeld && wHeld && !bvalid;

  always_ff @(posedge clock) begin
    if (rst) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      awAddrQ <= 4'h0;
      wDataQ  <= 32'h00000000;
      wStrbQ  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= srdm_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld  <= 1'b1;
        awready <= 1'b0;
        awAddrQ <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld  <= 1'b1;
        wready <= 1'b0;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        if (awAddrQ == srdm_pkg::OFF_SEG_REDIRECT || awAddrQ == srdm_pkg::OFF_REFRESH ||
            awAddrQ == srdm_pkg::OFF_CONTROL || awAddrQ == srdm_pkg::OFF_PINS) begin
          bresp <= srdm_pkg::RESP_OKAY;
        end else begin
          bresp <= srdm_pkg::RESP_SLVERR;
        end
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awHeld  <= 1'b0;
        wHeld   <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // register stores, low two byte lanes only
  always_ff @(posedge clock) begin
    if (rst) begin
      segRedirect     <= srdm_pkg::RST_SEG_REDIRECT;
      refreshInterval <= srdm_pkg::RST_REFRESH;
      reqFlag         <= srdm_pkg::RST_CONTROL[srdm_pkg::BIT_REQ];
      sizeSel         <= srdm_pkg::RST_CONTROL[srdm_pkg::BIT_SIZE];
      refreshOn       <= srdm_pkg::RST_CONTROL[srdm_pkg::BIT_REFON];
      pinPattern      <= srdm_pkg::RST_PINS;
    end else if (doWrite) begin
      if (awAddrQ == srdm_pkg::OFF_SEG_REDIRECT) begin
        if (wStrbQ[0]) segRedirect[7:0] <= wDataQ[7:0];
      end else if (awAddrQ == srdm_pkg::OFF_REFRESH) begin
        if (wStrbQ[0]) refreshInterval[7:0] <= wDataQ[7:0];
        if (wStrbQ[1]) refreshInterval[15:8] <= {5'h00, wDataQ[10:8]};
      end else if (awAddrQ == srdm_pkg::OFF_CONTROL) begin
        if (wStrbQ[0]) begin
          reqFlag   <= wDataQ[srdm_pkg::BIT_REQ];
          sizeSel   <= wDataQ[srdm_pkg::BIT_SIZE];
          refreshOn <= wDataQ[srdm_pkg::BIT_REFON];
        end
      end else if (awAddrQ == srdm_pkg::OFF_PINS) begin
        if (wStrbQ[0]) pinPattern <= {10'h000, wDataQ[5:0]};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi read: one cycle after address taken
  always_ff @(posedge clock) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= srdm_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= srdm_pkg::RESP_OKAY;
      if (araddr == srdm_pkg::OFF_SEG_REDIRECT) begin
        rdata <= {16'h0000, segRedirect};
      end else if (araddr == srdm_pkg::OFF_REFRESH) begin
        rdata <= {16'h0000, refreshInterval};
      end else if (araddr == srdm_pkg::OFF_CONTROL) begin
        rdata <= {28'h0000000, refreshOn, sizeSel, ackFlag, reqFlag};
      end else if (araddr == srdm_pkg::OFF_PINS) begin
        rdata <= {16'h0000, pinPattern};
      end else begin
        rdata <= 32'h00000000;
        rresp <= srdm_pkg::RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // refresh timer; tiny intervals starve traffic since refresh always wins
  always_ff @(posedge clock) begin
    if (rst || !refreshOn) begin
      refCount   <= 16'h0000;
      refreshReq <= 1'b0;
    end else if (refCount >= refreshInterval - 16'h0001) begin
      refCount   <= 16'h0000;
      refreshReq <= 1'b1;
    end else begin
      refCount   <= refCount + 16'h0001;
      refreshReq <= 1'b0;
    end
  end

  // pending refresh held while direct mode busy; no normal grant meanwhile
  always_ff @(posedge clock) begin
    if (rst) begin
      refPending <= 1'b0;
      accGrant   <= 1'b0;
    end else begin
      refPending <= refreshReq || (refPending && dState != srdm_pkg::DM_IDLE);
      accGrant   <= accValid && !refreshReq && !refPending && dState == srdm_pkg::DM_IDLE
                    && !reqFlag;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // direct mode four-phase handshake
  always_ff @(posedge clock) begin
    if (rst) begin
      dState  <= srdm_pkg::DM_IDLE;
      ackFlag <= 1'b0;
    end else begin
      case (dState)
        srdm_pkg::DM_IDLE: begin
          ackFlag <= 1'b0;
          if (reqFlag) begin
            dState <= srdm_pkg::DM_EXEC;
          end
        end
        srdm_pkg::DM_EXEC: begin
          ackFlag <= 1'b1;
          dState  <= srdm_pkg::DM_ACK;
        end
        srdm_pkg::DM_ACK: begin
          if (!reqFlag) begin
            ackFlag <= 1'b0;
            dState  <= srdm_pkg::DM_IDLE;
          end
        end
        default: dState <= srdm_pkg::DM_IDLE;
      endcase
    end
  end

  // sdram pins: pattern during the command cycle, normal machines when idle without request, deselected otherwise
  always_ff @(posedge clock) begin
    if (rst) begin
      sdramCsN  <= 1'b1;
      sdramRasN <= 1'b1;
      sdramCasN <= 1'b1;
      sdramWeN  <= 1'b1;
      sdramCke  <= 1'b1;
      sdramAddr <= 12'h000;
    end else if (dState == srdm_pkg::DM_EXEC) begin
      sdramAddr <= {srdm_pkg::MODE_WORD[11], pinPattern[0], srdm_pkg::MODE_WORD[9:0]};
      sdramWeN  <= pinPattern[1];
      sdramCasN <= pinPattern[2];
      sdramRasN <= pinPattern[3];
      sdramCsN  <= pinPattern[4];
      sdramCke  <= pinPattern[5];
    end else if (dState == srdm_pkg::DM_IDLE && !reqFlag) begin
      sdramCsN  <= fsmCsN;
      sdramRasN <= fsmRasN;
      sdramCasN <= fsmCasN;
      sdramWeN  <= fsmWeN;
      sdramCke  <= fsmCke;
      sdramAddr <= fsmAddr;
    end else begin
      sdramCsN  <= 1'b1; // deselect while waiting, keep clock enable
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // address map
  always_comb begin
    next_mapped = accAddr;
    if (accAddr[23:16] == srdm_pkg::SEG_REDIRECTED) begin
      next_mapped[23:16] = segRedirect[7:0];
    end
    next_hit = next_mapped[23];
    if (sizeSel) begin
      next_bank = next_mapped[22:21];
    end else begin
      next_bank = {1'b0, next_mapped[20]};
      next_hit  = next_mapped[23:21] == srdm_pkg::BANK_BASE[23:21];
    end
    if (romSizeField == 3'b110) begin
      next_rom2 = srdm_pkg::ROM2_B110;
    end else if (romSizeField == 3'b101) begin
      next_rom2 = srdm_pkg::ROM2_B101;
    end else if (romSizeField == 3'b100) begin
      next_rom2 = srdm_pkg::ROM2_B100;
    end else if (romSizeField == 3'b011) begin
      next_rom2 = srdm_pkg::ROM2_B011;
    end else if (romSizeField == 3'b111) begin
      next_rom2 = srdm_pkg::ROM2_NONE;
    end else begin
      next_rom2 = srdm_pkg::ROM2_OTHER;
    end
  end

  // strap caught once after reset release
  always_ff @(posedge clock) begin
    if (rst) begin
      strapTaken <= 1'b0;
      cselStrap  <= 1'b1;
    end else if (!strapTaken) begin
      strapTaken <= 1'b1;
      cselStrap  <= secondChipSelEn;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mappedAddr    <= 24'h000000;
      bankSel       <= 2'h0;
      sdramHit      <= 1'b0;
      rom2Base      <= 24'h000000;
      rom2Allowed   <= 1'b0;
      secondRomSelN <= 1'b1;
    end else begin
      mappedAddr    <= next_mapped;
      bankSel       <= next_bank;
      sdramHit      <= next_hit && accValid;
      rom2Base      <= next_rom2;
      rom2Allowed   <= romSizeField != 3'b111;
      secondRomSelN <= !(accValid && !cselStrap && romSizeField != 3'b111 && !next_hit
                         && next_mapped >= next_rom2);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  sequence s_cmd_start;
    dState == srdm_pkg::DM_IDLE && reqFlag;
  endsequence

  a_ack_after_exec: assert property (@(posedge clock) disable iff (rst)
    s_cmd_start |-> ##2 ackFlag) else $error("ack not raised after command");
  a_ack_held_req: assert property (@(posedge clock) disable iff (rst)
    ackFlag && reqFlag |=> ackFlag) else $error("ack dropped while request held");
  a_ack_clear_fast: assert property (@(posedge clock) disable iff (rst)
    ackFlag && !reqFlag |=> !ackFlag) else $error("ack not cleared");
  a_pins_from_pat: assert property (@(posedge clock) disable iff (rst)
    $past(dState) == srdm_pkg::DM_EXEC |-> sdramCsN == $past(pinPattern[4])
      && sdramRasN == $past(pinPattern[3])) else $error("pins not from pattern");
  a_refresh_off: assert property (@(posedge clock) disable iff (rst)
    !refreshOn |=> !refreshReq) else $error("refresh while disabled");
  a_refresh_wins: assert property (@(posedge clock) disable iff (rst)
    refreshReq |=> !accGrant) else $error("grant beside refresh");
  a_seg_redirect: assert property (@(posedge clock) disable iff (rst)
    accAddr[23:16] == 8'hFF |=> mappedAddr[23:16] == $past(segRedirect[7:0]))
    else $error("segment not redirected");
  a_cs_disabled: assert property (@(posedge clock) disable iff (rst)
    strapTaken && cselStrap |=> secondRomSelN) else $error("rom select active");
endmodule

// ### test/srdm_sdram_model.sv
`timescale 1ns/100ps
module srdm_sdram_model (
  input  wire logic        clock,     // bus clock
  input  wire logic        csN,       // chip select, low active
  input  wire logic        rasN,      // row strobe, low active
  input  wire logic        casN,      // column strobe, low active
  input  wire logic        weN,       // write enable, low active
  input  wire logic        cke,       // clock enable
  input  wire logic [11:0] addr,      // address lines
  output int               cmdCount,  // commands latched so far
  output logic [16:0]      lastCmd    // cke, csN, rasN, casN, weN, addr
);
  logic prevCke;
  initial begin
    cmdCount = 0;
    lastCmd = '0;
    prevCke = 1'b1;
  end
  // a powered-down or deselected part ignores the command pins
  always @(posedge clock) begin
    prevCke <= cke;
    if (prevCke && !csN) begin
      cmdCount <= cmdCount + 1;
      lastCmd <= {cke, csN, rasN, casN, weN, addr};
    end
  end
endmodule

// ### test/sdram_refresh_direct_mode_ctrl_bench.sv
`timescale 1ns/100ps
module sdram_refresh_direct_mode_ctrl_bench;
  localparam logic [1:0] OK    = srdm_pkg::RESP_OKAY;
  localparam logic [1:0] ERR   = srdm_pkg::RESP_SLVERR;
  localparam logic [3:0] A_SEG = srdm_pkg::OFF_SEG_REDIRECT;
  localparam logic [3:0] A_REF = srdm_pkg::OFF_REFRESH;
  localparam logic [3:0] A_CON = srdm_pkg::OFF_CONTROL;
  localparam logic [3:0] A_PIN = srdm_pkg::OFF_PINS;
  logic        clock, rst, awvalid, wvalid, bready, arvalid, rready, accValid, hit;
  logic        secondChipSelEn, fsmCsN, fsmRasN, fsmCasN, fsmWeN, fsmCke;
  logic        awready, wready, bvalid, arready, rvalid, sdramHit, accGrant, refreshReq;
  logic        rom2Allowed, secondRomSelN, sdramCsN, sdramRasN, sdramCasN, sdramWeN, sdramCke;
  logic [1:0]  bresp, rresp, bankSel;
  logic [2:0]  romSizeField;
  logic [3:0]  awaddr, wstrb, araddr;
  logic [11:0] fsmAddr, sdramAddr;
  logic [23:0] accAddr, mappedAddr, rom2Base, m;
  logic [31:0] wdata, rdata, rng, d;
  logic [16:0] lastCmd;
  logic [34:0] e;
  logic [34:0] expQ[$];
  logic [5:0]  pats[9] = '{6'h2E, 6'h25, 6'h20, 6'h22, 6'h02, 6'h30, 6'h10, 6'h30, 6'h30};
  logic [15:0] ivals[5] = '{16'h05DC, 16'h0617, 16'h040F, 16'h030B, 16'h0207};
  int          failures, n_checks, cycles, cmdCount, c0, n;

  srdm_ctrl i_srdm_ctrl (
    .clock, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .accAddr, .accValid, .romSizeField, .secondChipSelEn, .fsmCsN, .fsmRasN, .fsmCasN,
    .fsmWeN, .fsmCke, .fsmAddr, .mappedAddr, .bankSel, .sdramHit, .accGrant, .refreshReq,
    .rom2Base, .rom2Allowed, .secondRomSelN, .sdramCsN, .sdramRasN, .sdramCasN, .sdramWeN,
    .sdramCke, .sdramAddr
  );
  srdm_sdram_model i_srdm_sdram_model (
    .clock, .csN(sdramCsN), .rasN(sdramRasN), .casN(sdramCasN), .weN(sdramWeN),
    .cke(sdramCke), .addr(sdramAddr), .cmdCount, .lastCmd
  );

  always #10 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [33:0] ex, input logic [33:0] got);
    n_checks++;
    if (got !== ex) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, ex, got);
    end
  endtask
  function automatic logic [31:0] nextRand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [23:0] romBase(input logic [2:0] c);
    case (c)
      3'h7: return srdm_pkg::ROM2_NONE;
      3'h6: return 24'h200000;
      3'h5: return 24'h100000;
      3'h4: return 24'h080000;
      3'h3: return 24'h040000;
      default: return 24'h020000;
    endcase
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // each channel released only at the edge that takes it
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    logic done;
    @(posedge clock);
    done = 1'b0;
    expQ.push_back({1'b0, 32'h0, er});
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        bready <= 1'b0;
      end
    end
  endtask
  task automatic axiRead(input logic [3:0] a, input logic [34:0] ex, output logic [31:0] rd);
    logic done;
    @(posedge clock);
    done = 1'b0;
    expQ.push_back(ex);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        rd = rdata;
        rready <= 1'b0;
      end
    end
  endtask
  task automatic gap(output int g);
    g = 0;
    do begin
      @(posedge clock);
      g++;
    end while (refreshReq !== 1'b1 && g < 3000);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // a set top bit marks a polling read whose value is not predicted
  always @(posedge clock) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      e = expQ.pop_front();
      if (!e[34]) chk("bus answer", e[33:0], bvalid ? {32'h0, bresp} : {rdata, rresp});
    end
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("BAD timeout");
      summarize();
    end
  end
  initial begin
    {clock, awvalid, wvalid, bready, arvalid, rready, accValid, secondChipSelEn} = '0;
    {rst, fsmCsN, fsmRasN, fsmCasN, fsmWeN, fsmCke} = '1;
    {awaddr, araddr, wdata, fsmAddr, accAddr, romSizeField} = '0;
    wstrb = 4'hF;
    rng = 32'h00000044;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    axiRead(A_SEG, {1'b0, 32'h000000FF, OK}, d);
    axiRead(A_REF, {1'b0, 32'h000003E8, OK}, d);
    axiRead(A_CON, 35'h0, d);
    axiRead(A_PIN, 35'h0, d);
    axiRead(4'h2, {33'h0, ERR}, d);
    axiWrite(4'h6, 32'h0000FFFF, ERR);
    axiWrite(A_REF, 32'h0000FFFF, OK);
    axiRead(A_REF, {1'b0, 32'h000007FF, OK}, d);
    axiWrite(A_SEG, 32'h0000AB9A, OK);
    axiRead(A_SEG, {1'b0, 32'h0000009A, OK}, d);
    axiWrite(A_CON, 32'h0000000E, OK);
    axiRead(A_CON, {1'b0, 32'h0000000C, OK}, d);
    m[5:0] = 6'(nextRand());
    axiWrite(A_PIN, {26'h0, m[5:0]}, OK);
    axiRead(A_PIN, {1'b0, 26'h0, m[5:0], OK}, d);
    // intervals software picks for faster clocks and shorter retention
    foreach (ivals[i]) begin
      axiWrite(A_REF, {16'h0, ivals[i]}, OK);
      axiRead(A_REF, {1'b0, 16'h0, ivals[i], OK}, d);
    end
    $display("register access test done");
    accValid <= 1'b1;
    axiWrite(A_REF, 32'h00000008, OK);
    axiWrite(A_CON, 32'h00000008, OK);
    gap(n);
    repeat (2) begin
      gap(n);
      chk("refresh gap", 34'h8, 34'(n));
    end
    // grant drops in the cycle after the refresh pulse
    gap(n);
    @(posedge clock);
    chk("refresh grant", 34'h0, 34'(accGrant));
    axiWrite(A_CON, 32'h0, OK);
    c0 = 0;
    repeat (40) begin
      @(posedge clock);
      if (refreshReq) c0++;
    end
    chk("refresh off", 34'h0, 34'(c0));
    $display("refresh test done");
    // normal machine pins reach the device outside direct mode
    repeat (4) begin
      d = nextRand();
      c0 = cmdCount;
      fsmCsN <= 1'b0;
      {fsmRasN, fsmCasN, fsmWeN, fsmAddr} <= d[14:0];
      @(posedge clock);
      fsmCsN <= 1'b1;
      repeat (3) @(posedge clock);
      chk("pass count", 34'(c0 + 1), 34'(cmdCount));
      chk("pass pins", {17'h0, 2'h2, d[14:0]}, {17'h0, lastCmd});
    end
    foreach (pats[i]) begin
      axiWrite(A_PIN, {26'h0, pats[i]}, OK);
      c0 = cmdCount;
      axiWrite(A_CON, 32'h00000001, OK);
      n = 0;
      do begin
        axiRead(A_CON, {1'b1, 34'h0}, d);
        n++;
      end while (d[1] !== 1'b1 && n < 20);
      fsmCsN <= 1'b0;
      @(posedge clock);
      fsmCsN <= 1'b1;
      axiRead(A_CON, {1'b0, 32'h00000003, OK}, d);
      chk("grant in direct", 34'h0, 34'(accGrant));
      chk("cmd count", 34'(c0 + !pats[i][4]), 34'(cmdCount));
      if (!pats[i][4]) chk("cmd pins", {28'h0, pats[i]}, {28'h0, lastCmd[16:12], lastCmd[10]});
      if (pats[i] == 6'h20) chk("mode word", 34'h032, {22'h0, lastCmd[11:0]});
      axiWrite(A_CON, 32'h0, OK);
      axiRead(A_CON, {3'h0, 32'h0}, d);
    end
    $display("direct mode test done");
    for (int k = 0; k < 16; k++) begin
      if (k % 8 == 0) axiWrite(A_CON, {29'h0, k[3], 2'h0}, OK);
      d = nextRand();
      if (k % 3 == 0) d[23:16] = 8'hFF;
      accAddr <= d[23:0];
      accValid <= 1'b1;
      repeat (3) @(posedge clock);
      m = (d[23:16] == 8'hFF) ? {8'h9A, d[15:0]} : d[23:0];
      hit = k[3] ? m[23] : (m[23:21] == 3'h4);
      chk("mapped", {10'h0, m}, {10'h0, mappedAddr});
      chk("hit", 34'(hit), 34'(sdramHit));
      chk("grant", 34'h1, 34'(accGrant));
      if (hit) chk("bank", 34'(k[3] ? m[22:21] : {1'b0, m[20]}), 34'(bankSel));
    end
    for (int k = 0; k < 8; k++) begin
      romSizeField <= 3'(k);
      accAddr <= romBase(3'(k));
      repeat (3) @(posedge clock);
      chk("rom base", {10'h0, romBase(3'(k))}, {10'h0, rom2Base});
      chk("rom allowed", 34'(k != 7), 34'(rom2Allowed));
      chk("rom select", 34'(k == 7), 34'(secondRomSelN));
    end
    $display("address map test done");
    rst <= 1'b1;
    secondChipSelEn <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    axiRead(A_REF, {1'b0, 32'h000003E8, OK}, d);
    romSizeField <= 3'h6;
    accAddr <= 24'h200000;
    repeat (3) @(posedge clock);
    chk("rom select off", 34'h1, 34'(secondRomSelN));
    $display("strap test done");
    summarize();
  end
endmodule
